// ### scm_top.sv
// self-check mode entry, test sequencer and result pin driver
//
// Overview of operation
// RL1 - normal-range interrupt and capture pins select single-chip, mode lines ignored
// RL2 - high-voltage interrupt, capture high, line three low: self-check at reset
// RL3 - same entry, line three high: line four low loader, high jump mode
// RL4 - results appear on port C pins zero to three
// RL5 - all tests run automatically after entry and repeat until one fails; the watchdog verdict counts only once ctrl bit 0 is set
// RL6 - pass flashes the pins; failure holds one fixed value
// RL7 - each failing test holds its own four-bit fault code
// RL8 - pin low lights the indicator, pin high leaves it dark
// RL9 - fixture reads any unlisted held value as general failure
// RL10 - fixture switches five and six are ignored in self-check
// RL11 - port test exercises ports A through D
// RL12 - memory test counts through each RAM byte alone
// RL13 - ROM test xors contents and checks odd parity
// RL14 - timer test checks capture, compare and overflow flags
// RL15 - serial test checks receive, transmit and framing flags
// RL16 - converter test samples low, high and mid reference
// RL17 - pulse modulator, interrupts and watchdog are checked too
`timescale 1ns/100ps
`include "scm_map.svh"
module scm_top #(
  parameter int unsigned FLASH_CYC = `SCM_FLASH_CYC,
  parameter int unsigned STEP_CYC  = `SCM_STEP_CYC
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // entry straps, asynchronous pins
  input  wire logic       irq_high,
  input  wire logic       capture_one_pin,
  input  wire logic       mode_line_three,
  input  wire logic       mode_line_four,
  // fixture switches, unused while checking
  input  wire logic       fixture_switch_five,
  input  wire logic       fixture_switch_six,
  // per-test pass levels from the tested units, same clock
  input  wire logic [8:0] unit_ok,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // result pins and selected mode
  output logic      [3:0] result_pin,
  output logic      [3:0] result_oe,
  output logic      [1:0] mode_sel
);
  scm_pkg::scm_strap_s strap_s1, strap_s2;
  scm_pkg::scm_mode_e  mode;
  scm_pkg::scm_test_e  test;
  logic [1:0]  rst_seen;
  logic        latched;
  logic [31:0] flash_cnt;
  logic [31:0] step_cnt;
  logic [7:0]  ctrl;
  logic [7:0]  test_mask;
  logic        failed;
  logic [3:0]  fail_code;
  logic [3:0]  flash_pat;
  logic [2:0]  pass_cnt;

  // straps pass two flops before use
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      strap_s1 <= '0;
      strap_s2 <= '0;
    end else begin
      strap_s1 <= '{irq_high, capture_one_pin, mode_line_three,
                    mode_line_four};
      strap_s2 <= strap_s1;
    end
  end

  wire hv_entry = strap_s2.irq_high & strap_s2.capture_one_pin;
  // mode lines only matter under the high-voltage entry   see RL1
  wire scm_pkg::scm_mode_e next_mode =
    !hv_entry                  ? scm_pkg::SCM_MODE_SINGLE :   // see RL1
    !strap_s2.mode_line_three  ? scm_pkg::SCM_MODE_CHECK  :   // see RL2
    !strap_s2.mode_line_four   ? scm_pkg::SCM_MODE_LOADER :   // see RL3
                                 scm_pkg::SCM_MODE_JUMP;      // see RL3

  // mode is caught once, after the synchroniser has settled past release
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_seen <= 2'h0;
      latched  <= 1'b0;
      mode     <= scm_pkg::SCM_MODE_SINGLE;
    end else begin
      rst_seen <= {rst_seen[0], 1'b1};
      if (rst_seen[1] && !latched) begin
        latched <= 1'b1;
        mode    <= next_mode;
      end
    end
  end

  wire checking = latched && (mode == scm_pkg::SCM_MODE_CHECK);
  // switches five and six never reach the sequencer   see RL10
  wire unused_sw = fixture_switch_five ^ fixture_switch_six;

  // test enable mask: bit n allows test n, ctrl bit 0 allows the watchdog; the unit must report its ok
  wire [8:0] eff_ok = unit_ok | ~{ctrl[`SCM_CTRL_STEP_BIT], test_mask};
  wire       step_end = (step_cnt >= STEP_CYC - 1);
  wire       cur_ok = eff_ok[test];
  wire       last_test = (test == scm_pkg::SCM_T_WDOG);

  logic [3:0] code_of;
  always_comb begin
    code_of = `SCM_CODE_PORT_A;
    unique case (test)
      scm_pkg::SCM_T_PORT:   code_of = `SCM_CODE_PORT_A;  // see RL11
      scm_pkg::SCM_T_RAM:    code_of = `SCM_CODE_RAM;     // see RL12
      scm_pkg::SCM_T_ROM:    code_of = `SCM_CODE_ROM;     // see RL13
      scm_pkg::SCM_T_TIMER:  code_of = `SCM_CODE_TIMER;   // see RL14
      scm_pkg::SCM_T_SERIAL: code_of = `SCM_CODE_SERIAL;  // see RL15
      scm_pkg::SCM_T_CONV:   code_of = `SCM_CODE_CONV;    // see RL16
      scm_pkg::SCM_T_PLM:    code_of = `SCM_CODE_PLM;     // see RL17
      scm_pkg::SCM_T_INTR:   code_of = `SCM_CODE_INTR;    // see RL17
      scm_pkg::SCM_T_WDOG:   code_of = `SCM_CODE_WDOG;    // see RL17
      default:               code_of = `SCM_CODE_PORT_B;
    endcase
  end

  wire scm_pkg::scm_test_e next_test =
    last_test ? scm_pkg::SCM_T_PORT
              : scm_pkg::scm_test_e'(test + 4'h1);

  // sequencer: each test holds STEP_CYC cycles, verdict at its end
  // a failure freezes it, so the code stays put until the next reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      test      <= scm_pkg::SCM_T_PORT;
      step_cnt  <= '0;
      failed    <= 1'b0;
      fail_code <= 4'hF;
      pass_cnt  <= '0;
    end else if (checking && !failed) begin
      step_cnt <= step_end ? 32'h0 : step_cnt + 32'h1;
      if (step_end) begin
        if (!cur_ok) begin
          failed    <= 1'b1;                                  // see RL6
          fail_code <= code_of;                               // see RL7
        end else begin
          test <= next_test;                                  // see RL5
          if (last_test) begin
            pass_cnt <= pass_cnt + 3'h1;
          end
        end
      end
    end
  end

  // flash timer only runs while the device is passing
  wire flash_end = (flash_cnt >= FLASH_CYC - 1);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flash_cnt <= '0;
      flash_pat <= 4'hF;
    end else if (checking && !failed) begin
      flash_cnt <= flash_end ? 32'h0 : flash_cnt + 32'h1;
      if (flash_end) begin
        flash_pat <= ~flash_pat;                              // see RL6
      end
    end
  end

  // pins: low lights an indicator, so dark (1) outside self-check
  wire [3:0] next_pins = !checking ? 4'hF :
                         failed    ? fail_code : flash_pat;  // see RL8
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      result_pin <= 4'hF;
      result_oe  <= 4'h0;
      mode_sel   <= 2'h0;
    end else begin
      result_pin <= next_pins;                                // see RL4
      result_oe  <= {4{checking}};                            // see RL4
      mode_sel   <= mode;
    end
  end

  // register port, carried as one bundle
  wire scm_pkg::scm_bus_s bus = '{reg_wr, reg_rd, reg_addr, reg_wdata};
  wire wr_ctrl   = bus.wr && (bus.addr == `SCM_ADDR_CTRL);
  wire wr_testok = bus.wr && (bus.addr == `SCM_ADDR_TESTOK);
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    unique case (bus.addr)
      `SCM_ADDR_CTRL:   next_rdata = ctrl;
      // pass count wraps at eight: a sign of life, not a tally
      `SCM_ADDR_STATUS: next_rdata = {pass_cnt, unused_sw & 1'b0, failed,
                                      checking, mode};
      `SCM_ADDR_RESULT: next_rdata = {test, fail_code};
      `SCM_ADDR_TESTOK: next_rdata = test_mask;
      default:          next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl      <= `SCM_CTRL_RESET;
      test_mask <= `SCM_TESTOK_RESET;
      reg_rdata <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl <= bus.wdata;
      end
      if (wr_testok) begin
        test_mask <= bus.wdata;
      end
      reg_rdata <= bus.rd ? next_rdata : 8'h00;
    end
  end

  // checks
  property p_fail_holds;
    @(posedge clk_sys) disable iff (!arst_n)
      (checking && failed) |=> ##1 (result_pin == fail_code) [*4];
  endproperty
  fail_hold_a: assert property (p_fail_holds)  // see RL6
    else $error("fault code not held");

  single_mode_a: assert property (  // see RL1
    @(posedge clk_sys) disable iff (!arst_n)
      (rst_seen[1] && !latched && !hv_entry) |=>
        (mode == scm_pkg::SCM_MODE_SINGLE))
    else $error("single-chip not chosen");

  check_mode_a: assert property (  // see RL2
    @(posedge clk_sys) disable iff (!arst_n)
      (rst_seen[1] && !latched && hv_entry && !strap_s2.mode_line_three)
        |=> (mode == scm_pkg::SCM_MODE_CHECK))
    else $error("self-check not chosen");

  loader_mode_a: assert property (  // see RL3
    @(posedge clk_sys) disable iff (!arst_n)
      (rst_seen[1] && !latched && hv_entry && strap_s2.mode_line_three)
        |=> (mode == (strap_s2.mode_line_four ? scm_pkg::SCM_MODE_JUMP
                                               : scm_pkg::SCM_MODE_LOADER)))
    else $error("loader or jump mode wrong");

  pin_drive_a: assert property (  // see RL4
    @(posedge clk_sys) disable iff (!arst_n)
      checking |=> (result_oe == 4'hF))
    else $error("result pins not driven");

  wrap_seq_a: assert property (  // see RL5
    @(posedge clk_sys) disable iff (!arst_n)
      (checking && !failed && step_end && last_test && cur_ok) |=>
        (test == scm_pkg::SCM_T_PORT))
    else $error("sequence did not restart");

  // a failing verdict: flag and code land, then the pins show the code
  sequence s_fault_taken;
    failed && (fail_code == $past(code_of));
  endsequence
  sequence s_code_shown;
    result_pin == fail_code;
  endsequence

  code_set_a: assert property (  // see RL7
    @(posedge clk_sys) disable iff (!arst_n)
      (checking && !failed && step_end && !cur_ok) |=>
        s_fault_taken ##1 s_code_shown)
    else $error("fault code wrong");

  flash_flip_a: assert property (  // see RL6
    @(posedge clk_sys) disable iff (!arst_n)
      (checking && !failed && flash_end) |=> ##1
        (result_pin == ~$past(flash_pat, 2) || failed))
    else $error("flash pattern not toggled");

  idle_dark_a: assert property (  // see RL4
    @(posedge clk_sys) disable iff (!arst_n)
      !checking |=> (result_oe == 4'h0) && (result_pin == 4'hF))
    else $error("result pins active outside self-check");

  mode_once_a: assert property (  // see RL2
    @(posedge clk_sys) disable iff (!arst_n)
      latched |=> latched && $stable(mode))
    else $error("mode changed after reset");

  step_bound_a: assert property (  // see RL5
    @(posedge clk_sys) disable iff (!arst_n)
      step_cnt < STEP_CYC)
    else $error("step counter overran");

  test_order_a: assert property (  // see RL5
    @(posedge clk_sys) disable iff (!arst_n)
      (checking && !failed && step_end && cur_ok && !last_test) |=>
        (test == scm_pkg::scm_test_e'($past(test) + 4'h1)))
    else $error("tests out of order");

  pass_count_a: assert property (  // see RL5
    @(posedge clk_sys) disable iff (!arst_n)
      (checking && !failed && step_end && last_test && cur_ok) |=>
        (pass_cnt == 3'($past(pass_cnt) + 3'h1)))
    else $error("pass not counted");

  fail_freeze_a: assert property (  // see RL6
    @(posedge clk_sys) disable iff (!arst_n)
      (checking && failed) |=> failed && $stable(test))
    else $error("sequencer ran on after a failure");
endmodule

// ### scm_map.svh
// offsets, field positions, reset values and timing counts of the self-check
`ifndef SCM_MAP_SVH
`define SCM_MAP_SVH
`define SCM_ADDR_CTRL      4'h0
`define SCM_ADDR_STATUS    4'h1
`define SCM_ADDR_RESULT    4'h2
`define SCM_ADDR_TESTOK    4'h3
`define SCM_CTRL_RESET     8'h00
`define SCM_TESTOK_RESET   8'hFF
`define SCM_CTRL_STEP_BIT  0
`define SCM_FLASH_NS       100000000
`define SCM_CLK_NS         10
`define SCM_FLASH_CYC      (`SCM_FLASH_NS / `SCM_CLK_NS)
`define SCM_STEP_NS        1000
`define SCM_STEP_CYC       (`SCM_STEP_NS / `SCM_CLK_NS)
`define SCM_CODE_PORT_A    4'h9
`define SCM_CODE_PORT_B    4'h6
`define SCM_CODE_RAM       4'hA
`define SCM_CODE_ROM       4'hB
`define SCM_CODE_TIMER     4'hC
`define SCM_CODE_SERIAL    4'hD
`define SCM_CODE_CONV      4'hE
`define SCM_CODE_PLM       4'h1
`define SCM_CODE_INTR      4'h2
`define SCM_CODE_WDOG      4'h3
`endif

// ### scm_pkg.sv
// types of the self-check mode indicator
package scm_pkg;
  typedef enum logic [1:0] {
    SCM_MODE_SINGLE = 2'b00,
    SCM_MODE_CHECK  = 2'b01,
    SCM_MODE_LOADER = 2'b10,
    SCM_MODE_JUMP   = 2'b11
  } scm_mode_e;
  typedef enum logic [3:0] {
    SCM_T_PORT   = 4'b0000,
    SCM_T_RAM    = 4'b0001,
    SCM_T_ROM    = 4'b0010,
    SCM_T_TIMER  = 4'b0011,
    SCM_T_SERIAL = 4'b0100,
    SCM_T_CONV   = 4'b0101,
    SCM_T_PLM    = 4'b0110,
    SCM_T_INTR   = 4'b0111,
    SCM_T_WDOG   = 4'b1000
  } scm_test_e;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } scm_bus_s;
  typedef struct packed {
    logic irq_high;
    logic capture_one_pin;
    logic mode_line_three;
    logic mode_line_four;
  } scm_strap_s;
endpackage

// ### scm_fixture.sv
// test fixture model: entry straps, switches and indicator lamps
`timescale 1ns/100ps
module scm_fixture (
  // controls from the bench
  input  wire logic       hv_entry,
  input  wire logic [1:0] line_set,
  input  wire logic       sw_set,
  // device pins
  input  wire logic [3:0] result_pin,
  input  wire logic [3:0] result_oe,
  output logic            irq_high,
  output logic            capture_one_pin,
  output logic            mode_line_three,
  output logic            mode_line_four,
  output logic            fixture_switch_five,
  output logic            fixture_switch_six,
  // lamps and verdict
  output logic      [3:0] lamp_lit,
  output logic            general_fail
);
  logic [3:0] pin_level;
  assign irq_high        = hv_entry;
  assign capture_one_pin = hv_entry;
  assign mode_line_three = line_set[0];
  assign mode_line_four  = line_set[1];
  // switches flip apart so an ignored pair really moves
  assign fixture_switch_five = sw_set;
  assign fixture_switch_six  = ~sw_set;
  // a released pin floats high through its lamp resistor
  assign pin_level = (result_pin & result_oe) | ~result_oe;
  assign lamp_lit  = ~pin_level;
  assign general_fail = !(pin_level inside {4'h9, 4'h6, 4'hA, 4'hB,
    4'hC, 4'hD, 4'hE, 4'h1, 4'h2, 4'h3});
endmodule

// ### tb_top.sv
// self-checking bench for the self-check mode indicator
`timescale 1ns/100ps
module tb_top;
  // short counts keep the run brief
  localparam int FLASH = 8;
  localparam int STEP  = 4;
  logic       clk_sys   = 1'b0;
  logic       arst_n    = 1'b0;
  logic       hv_entry  = 1'b0;
  logic [1:0] line_set  = 2'b00;
  logic       sw_set    = 1'b0;
  logic [8:0] unit_ok   = 9'h1FF;
  logic [3:0] reg_addr  = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] rd_val;
  logic [3:0] result_pin;
  logic [3:0] result_oe;
  logic [3:0] lamp_lit;
  logic [1:0] mode_sel;
  logic       irq_high;
  logic       capture_one_pin;
  logic       mode_line_three;
  logic       mode_line_four;
  logic       fixture_switch_five;
  logic       fixture_switch_six;
  logic       general_fail;
  int         err_total = 0;
  int         checks    = 0;
  logic [3:0] codes [9] = '{4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'h1,
                            4'h2, 4'h3};

  always #5 clk_sys = ~clk_sys;

  scm_top #(.FLASH_CYC(FLASH), .STEP_CYC(STEP)) i_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .irq_high(irq_high),
    .capture_one_pin(capture_one_pin), .mode_line_three(mode_line_three),
    .mode_line_four(mode_line_four),
    .fixture_switch_five(fixture_switch_five),
    .fixture_switch_six(fixture_switch_six), .unit_ok(unit_ok),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .result_pin(result_pin),
    .result_oe(result_oe), .mode_sel(mode_sel));

  scm_fixture i_fix (
    .hv_entry(hv_entry), .line_set(line_set), .sw_set(sw_set),
    .result_pin(result_pin), .result_oe(result_oe), .irq_high(irq_high),
    .capture_one_pin(capture_one_pin), .mode_line_three(mode_line_three),
    .mode_line_four(mode_line_four),
    .fixture_switch_five(fixture_switch_five),
    .fixture_switch_six(fixture_switch_six), .lamp_lit(lamp_lit),
    .general_fail(general_fail));

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  // straps must settle before release, the mode is latched once
  task automatic start(input logic hv, input logic [1:0] ln,
                       input logic [8:0] ok);
    @(posedge clk_sys);
    arst_n   <= 1'b0;
    hv_entry <= hv;
    line_set <= ln;
    unit_ok  <= ok;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    #1;
  endtask

  task automatic flashing(input string what);
    int         chg;
    logic [3:0] last;
    chg  = 0;
    last = result_pin;
    repeat (4 * FLASH) begin
      @(posedge clk_sys);
      #1;
      if (result_pin !== last) chg++;
      last = result_pin;
    end
    chk(what, 8'(chg >= 3), 8'h01);
  endtask

  task automatic test_done;
    $display("checks %0d, errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 4; i++) begin
      start(1'b0, 2'(i), 9'h1FF);
      chk("mode", 8'(mode_sel), 8'h00);
      chk("oe", 8'(result_oe), 8'h00);
      chk("general", 8'(general_fail), 8'h01);
    end
    start(1'b1, 2'b01, 9'h1FF);
    chk("mode", 8'(mode_sel), 8'h02);
    start(1'b1, 2'b11, 9'h1FF);
    chk("mode", 8'(mode_sel), 8'h03);
    start(1'b1, 2'b10, 9'h1FF);
    chk("mode", 8'(mode_sel), 8'h01);
    chk("oe", 8'(result_oe), 8'h0F);
    reg_read(4'h1);
    chk("status", rd_val, 8'h05);
    reg_read(4'h3);
    chk("testok", rd_val, 8'hFF);
    reg_read(4'h7);
    chk("unmapped", rd_val, 8'h00);
    flashing("flash");
    @(posedge clk_sys);
    sw_set <= 1'b1;
    flashing("flash again");
    reg_read(4'h1);
    chk("passes", 8'(rd_val[7:5] != 3'h0), 8'h01);
    for (int n = 0; n < 9; n++) begin
      start(1'b1, 2'b00, ~(9'h001 << n));
      reg_write(4'h0, 8'h01);
      repeat (12 * STEP) @(posedge clk_sys);
      #1;
      chk("code", 8'(result_pin), 8'(codes[n]));
      chk("listed", 8'(general_fail), 8'h00);
      chk("lamp", 8'(lamp_lit), {4'h0, ~codes[n]});
      repeat (2 * FLASH) @(posedge clk_sys);
      #1;
      chk("held", 8'(result_pin), 8'(codes[n]));
      reg_read(4'h2);
      chk("result", 8'(rd_val[3:0]), 8'(codes[n]));
    end
    // masked RAM failure and unchecked watchdog both still flash
    start(1'b1, 2'b00, 9'h1FD);
    reg_write(4'h3, 8'hFD);
    flashing("masked");
    start(1'b1, 2'b00, 9'h0FF);
    flashing("watchdog off");
    test_done();
  end
endmodule
